// ---- sacc_consts.svh ----
// Notes on behaviour
// R1: Five-bit selector: 0-5, 8-9 pins; 26 temp, 27 bandgap, 29 high ref, 30 low ref.
// R2: Reserved selector codes still convert; the result value is simply undefined.
// R3: Continuous mode starts the next conversion right after the current one completes.
// R4: Software trigger plus continuous: series starts on first control write, runs until aborted.
// R5: Hardware trigger plus continuous: series starts on trigger event, runs until aborted.
// R6: Completion means result moved into result registers; completion flag set then.
// R7: Interrupt request raised when completion flag sets while interrupt enable is high.
// R8: In 12/10-bit mode, high byte read without low byte blocks transfer and flag.
// R9: Single conversion, compare enabled, compare false: ignore blocking, stop converting.
// R10: Any other blocked transfer starts another conversion, single or continuous.
// R11: Software should not read results during a single conversion, avoiding discarded conversions.
// R12: Writing first control register aborts; new conversion starts unless selector is all ones.
// R13: Writes to second control, configuration or compare registers abort the conversion.
// R14: Entering stop mode without the async conversion clock aborts the conversion.
// R15: Non-reset aborts leave result registers with the last completed result.
// R16: Reset aborts any conversion and returns result registers to reset values.
// R17: Idle until started; async clock generator enabled only while converting.
// R18: Low-power bit selects reduced-power active state, slower conversion clock.
// R19: Selector all ones means converter disabled, no conversion starts.
`ifndef SACC_CONSTS_SVH
`define SACC_CONSTS_SVH

// Register byte offsets
`define SACC_OFS_SC1      8'h00
`define SACC_OFS_SC2      8'h04
`define SACC_OFS_CFG      8'h08
`define SACC_OFS_CVH      8'h0C
`define SACC_OFS_CVL      8'h10
`define SACC_OFS_RH       8'h14
`define SACC_OFS_RL       8'h18

// status_control_first fields
`define SACC_SC1_CONVERSION_COMPLETE_FLAG     7
`define SACC_SC1_COMPLETE_INTERRUPT_ENABLE     6
`define SACC_SC1_CONTINUOUS_CONVERSION_ENABLE     5
`define SACC_SC1_CH_HI    4
// status_control_second fields
`define SACC_SC2_ACT      7
`define SACC_SC2_HWTRG    6
`define SACC_SC2_CMPEN    5
`define SACC_SC2_CMPGT    4
// converter_configuration fields
`define SACC_CFG_LP       7
`define SACC_CFG_DIV_HI   6
`define SACC_CFG_DIV_LO   5
`define SACC_CFG_MODE_HI  3
`define SACC_CFG_MODE_LO  2
`define SACC_CFG_CLK_HI   1
`define SACC_CFG_CLK_LO   0

// Field encodings and reset values
`define SACC_MODE_8       2'h0
`define SACC_MODE_12      2'h1
`define SACC_MODE_10      2'h2
`define SACC_CLK_ASYNC    2'h3
`define SACC_CH_OFF       5'h1F
`define SACC_CH_TEMP      5'h1A
`define SACC_CH_BGAP      5'h1B
`define SACC_CH_VREFH     5'h1D
`define SACC_CH_VREFL     5'h1E
`define SACC_RST_CH       5'h1F
`define SACC_RST_BYTE     8'h00

// Timing counts in conversion clock ticks
`define SACC_SAMPLE_TICKS 4

`endif

// ---- sacc_pkg.sv ----
package sacc_pkg;

	// Control sequencing
	typedef enum logic [1:0] {CTL_IDLE, CTL_ARMED, CTL_BUSY} sacc_ctl_t;

	// Approximation engine
	typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_TRIAL} sacc_sar_t;

	// Analogue source kind behind the selector
	typedef enum logic [2:0] {SRC_PIN, SRC_TEMP, SRC_BGAP, SRC_VREFH, SRC_VREFL,
		SRC_RESERVED, SRC_OFF} sacc_src_t;

endpackage

// ---- sacc_sar.sv ----
`timescale 1ns/1ps
`include "sacc_consts.svh"
module sacc_sar
	import sacc_pkg::*;
#(
	parameter int WIDTH = 12
)(
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic             start,
	input  wire logic             abort,
	input  wire logic             tick,
	input  wire logic             cmp_in,
	output logic                  busy,
	output logic                  sample_en,
	output logic [WIDTH-1:0]      dac_code,
	output logic                  done,
	output logic [WIDTH-1:0]      result
);

	sacc_sar_t          state_reg;
	logic [3:0]         cnt_reg;
	logic [WIDTH-1:0]   bit_reg;

	// Start wins over abort so a restart in the abort cycle is honoured
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= SAR_IDLE;
			cnt_reg   <= 4'h0;
			bit_reg   <= '0;
			dac_code  <= '0;
			result    <= '0;
			done      <= 1'b0;
			sample_en <= 1'b0;
			busy      <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				state_reg <= SAR_SAMPLE;
				cnt_reg   <= 4'h0;
				sample_en <= 1'b1;
				busy      <= 1'b1;
			end
			else if (abort)
			begin
				state_reg <= SAR_IDLE; // see R14
				sample_en <= 1'b0;
				busy      <= 1'b0;
			end
			else if (tick)
			begin
				case (state_reg)
					SAR_SAMPLE:
					begin
						if (cnt_reg == 4'(`SACC_SAMPLE_TICKS - 1))
						begin
							state_reg <= SAR_TRIAL;
							sample_en <= 1'b0;
							bit_reg   <= {1'b1, {(WIDTH-1){1'b0}}};
							dac_code  <= {1'b1, {(WIDTH-1){1'b0}}};
						end
						cnt_reg <= cnt_reg + 4'h1;
					end
					SAR_TRIAL:
					begin
						// Keep the trial bit when input is above the DAC level
						if (bit_reg[0])
						begin
							result    <= cmp_in ? dac_code : (dac_code & ~bit_reg);
							done      <= 1'b1;
							busy      <= 1'b0;
							state_reg <= SAR_IDLE;
						end
						else
						begin
							dac_code <= (cmp_in ? dac_code : (dac_code & ~bit_reg))
								| (bit_reg >> 1);
							bit_reg  <= bit_reg >> 1;
						end
					end
					default:
						state_reg <= SAR_IDLE;
				endcase
			end
		end
	end

endmodule

// ---- sacc_top.sv ----
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "sacc_consts.svh"
module sacc_top
	import sacc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        hw_trigger_pin,
	input  wire logic        stop_mode_req,
	input  wire logic        comparator_in,
	output logic [4:0]       input_channel_out,
	output sacc_src_t        input_source,
	output logic             sample_en,
	output logic [11:0]      dac_code,
	output logic             async_clock_enable,
	output logic             low_power_config,
	output logic             conversion_active,
	output logic             complete_irq
);

	// Bus handshake and registers
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic        complete_interrupt_enable_reg, continuous_conversion_enable_reg;
	logic [4:0]  chsel_reg;
	logic        hwtrg_reg, cmpen_reg, cmpgt_reg;
	logic        lp_reg;
	logic [1:0]  div_reg, mode_reg, clksel_reg;
	logic [3:0]  cvh_reg;
	logic [7:0]  cvl_reg, rh_reg, rl_reg;
	logic        conversion_complete_flag_reg, lock_reg;
	sacc_ctl_t   ctl_reg;
	logic        start_reg, abort_reg;
	logic [3:0]  div_cnt_reg;
	logic        tick_reg;
	logic [2:0]  trg_sync_reg, stop_sync_reg;
	logic [1:0]  cmp_sync_reg;
	logic [31:0] rd_val;
	sacc_src_t   src_next;

	wire        addr_ok = hsel & hready & htrans[1];
	wire        rd_acc  = addr_ok & ~hwrite;
	wire [7:0]  wdat    = hwdata[7:0];
	wire        wr_sc1  = wr_pend_reg && (wr_addr_reg == `SACC_OFS_SC1);
	wire        wr_sc2  = wr_pend_reg && (wr_addr_reg == `SACC_OFS_SC2);
	wire        wr_cfg  = wr_pend_reg && (wr_addr_reg == `SACC_OFS_CFG);
	wire        wr_cvh  = wr_pend_reg && (wr_addr_reg == `SACC_OFS_CVH);
	wire        wr_cvl  = wr_pend_reg && (wr_addr_reg == `SACC_OFS_CVL);
	wire        rd_rh   = rd_acc && (haddr[7:0] == `SACC_OFS_RH);
	wire        rd_rl   = rd_acc && (haddr[7:0] == `SACC_OFS_RL);

	// Writes land in the data phase; address is held from the address phase
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end
		else
		begin
			wr_pend_reg <= addr_ok & hwrite;
			wr_addr_reg <= haddr[7:0];
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		rd_val = 32'h0000_0000;
		case (haddr[7:0])
			`SACC_OFS_SC1: rd_val[7:0] = {conversion_complete_flag_reg, complete_interrupt_enable_reg, continuous_conversion_enable_reg, chsel_reg};
			`SACC_OFS_SC2: rd_val[7:0] = {ctl_reg == CTL_BUSY, hwtrg_reg, cmpen_reg,
				cmpgt_reg, 4'h0};
			`SACC_OFS_CFG: rd_val[7:0] = {lp_reg, div_reg, 1'b0, mode_reg, clksel_reg};
			`SACC_OFS_CVH: rd_val[7:0] = {4'h0, cvh_reg};
			`SACC_OFS_CVL: rd_val[7:0] = cvl_reg;
			`SACC_OFS_RH:  rd_val[7:0] = rh_reg;
			`SACC_OFS_RL:  rd_val[7:0] = rl_reg;
			default:       rd_val = 32'h0000_0000;
		endcase
	end

	// Read data is registered at the address phase so it stands in the data phase
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			hrdata <= 32'h0000_0000;
		else if (rd_acc)
			hrdata <= rd_val;
	end

	// Software-written control fields
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			complete_interrupt_enable_reg   <= 1'b0;
			continuous_conversion_enable_reg   <= 1'b0;
			chsel_reg  <= `SACC_RST_CH;
			hwtrg_reg  <= 1'b0;
			cmpen_reg  <= 1'b0;
			cmpgt_reg  <= 1'b0;
			lp_reg     <= 1'b0;
			div_reg    <= 2'h0;
			mode_reg   <= `SACC_MODE_8;
			clksel_reg <= 2'h0;
			cvh_reg    <= 4'h0;
			cvl_reg    <= `SACC_RST_BYTE;
		end
		else
		begin
			if (wr_sc1)
			begin
				complete_interrupt_enable_reg  <= wdat[`SACC_SC1_COMPLETE_INTERRUPT_ENABLE];
				continuous_conversion_enable_reg  <= wdat[`SACC_SC1_CONTINUOUS_CONVERSION_ENABLE];
				chsel_reg <= wdat[`SACC_SC1_CH_HI:0];
			end
			if (wr_sc2)
			begin
				hwtrg_reg <= wdat[`SACC_SC2_HWTRG];
				cmpen_reg <= wdat[`SACC_SC2_CMPEN];
				cmpgt_reg <= wdat[`SACC_SC2_CMPGT];
			end
			if (wr_cfg)
			begin
				lp_reg     <= wdat[`SACC_CFG_LP];
				div_reg    <= wdat[`SACC_CFG_DIV_HI:`SACC_CFG_DIV_LO];
				mode_reg   <= wdat[`SACC_CFG_MODE_HI:`SACC_CFG_MODE_LO];
				clksel_reg <= wdat[`SACC_CFG_CLK_HI:`SACC_CFG_CLK_LO];
			end
			if (wr_cvh)
				cvh_reg <= wdat[3:0];
			if (wr_cvl)
				cvl_reg <= wdat;
		end
	end

	// Pin synchronisers; only the second stage onward is looked at
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			trg_sync_reg  <= 3'h0;
			stop_sync_reg <= 3'h0;
			cmp_sync_reg  <= 2'h0;
		end
		else
		begin
			trg_sync_reg  <= {trg_sync_reg[1:0], hw_trigger_pin};
			stop_sync_reg <= {stop_sync_reg[1:0], stop_mode_req};
			cmp_sync_reg  <= {cmp_sync_reg[0], comparator_in};
		end
	end

	wire trig_rise  = trg_sync_reg[1] & ~trg_sync_reg[2];
	wire stop_now   = stop_sync_reg[1];
	wire async_sel  = (clksel_reg == `SACC_CLK_ASYNC);
	wire stop_abort = stop_now & ~async_sel & (ctl_reg == CTL_BUSY); // see R14

	// Conversion clock divider; low power halves the rate again
	wire [2:0] div_exp = {1'b0, div_reg} + {2'b00, lp_reg}; // see R18
	wire [3:0] div_top = 4'((5'h01 << div_exp) - 5'h01);
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			div_cnt_reg <= 4'h0;
			tick_reg    <= 1'b0;
		end
		else if (div_cnt_reg >= div_top)
		begin
			div_cnt_reg <= 4'h0;
			tick_reg    <= 1'b1;
		end
		else
		begin
			div_cnt_reg <= div_cnt_reg + 4'h1;
			tick_reg    <= 1'b0;
		end
	end

	// Approximation engine
	logic        eng_busy, eng_done;
	logic [11:0] eng_result;
	sacc_sar #(
		.WIDTH (12)
	) u_sar (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.start     (start_reg),
		.abort     (abort_reg),
		.tick      (tick_reg),
		.cmp_in    (cmp_sync_reg[1]),
		.busy      (eng_busy),
		.sample_en (sample_en),
		.dac_code  (dac_code),
		.done      (eng_done),
		.result    (eng_result)
	);

	// Result justified to the selected resolution, compare value masked alike
	wire [11:0] res_j = (mode_reg == `SACC_MODE_12) ? eng_result :
		(mode_reg == `SACC_MODE_10) ? {2'h0, eng_result[11:2]} : {4'h0, eng_result[11:4]};
	wire [11:0] cv_j  = (mode_reg == `SACC_MODE_12) ? {cvh_reg, cvl_reg} :
		(mode_reg == `SACC_MODE_10) ? {2'h0, cvh_reg[1:0], cvl_reg} : {4'h0, cvl_reg};
	wire cmp_true  = ~cmpen_reg | (cmpgt_reg ? (res_j >= cv_j) : (res_j < cv_j));
	wire blocked   = lock_reg & (mode_reg != `SACC_MODE_8); // see R8
	wire xfer      = eng_done & ~blocked & cmp_true; // see R6
	// Single conversions end unless blocked; compare-false single ends regardless
	wire finish    = ~continuous_conversion_enable_reg & ((cmpen_reg & ~cmp_true) | ~blocked); // see R9
	wire restart   = eng_done & ~finish; // see R3 R10
	wire ch_on_w   = (wdat[`SACC_SC1_CH_HI:0] != `SACC_CH_OFF);
	wire hw_next   = wr_sc2 ? wdat[`SACC_SC2_HWTRG] : hwtrg_reg;
	wire ch_on     = (chsel_reg != `SACC_CH_OFF);

	// Conversion sequencing; aborts outrank completion and triggers
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctl_reg   <= CTL_IDLE; // see R16
			start_reg <= 1'b0;
			abort_reg <= 1'b0;
		end
		else
		begin
			start_reg <= 1'b0;
			abort_reg <= 1'b0;
			if (wr_sc1)
			begin
				abort_reg <= 1'b1; // see R12
				if (!ch_on_w)
					ctl_reg <= CTL_IDLE; // see R19
				else if (!hwtrg_reg && !stop_now)
				begin
					ctl_reg   <= CTL_BUSY; // see R4
					start_reg <= 1'b1;
				end
				else
					ctl_reg <= hwtrg_reg ? CTL_ARMED : CTL_IDLE;
			end
			else if (wr_sc2 || wr_cfg || wr_cvh || wr_cvl || stop_abort)
			begin
				abort_reg <= 1'b1; // see R13 R14
				ctl_reg   <= (hw_next && ch_on) ? CTL_ARMED : CTL_IDLE;
			end
			else if (ctl_reg == CTL_BUSY && eng_done)
			begin
				if (restart)
					start_reg <= 1'b1;
				else
					ctl_reg <= hwtrg_reg ? CTL_ARMED : CTL_IDLE;
			end
			else if (ctl_reg == CTL_ARMED && trig_rise && ch_on && !stop_now)
			begin
				ctl_reg   <= CTL_BUSY; // see R5
				start_reg <= 1'b1;
			end
		end
	end

	// Results change only on a completed transfer, so aborts keep the last one
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rh_reg <= `SACC_RST_BYTE; // see R16
			rl_reg <= `SACC_RST_BYTE;
		end
		else if (xfer && ctl_reg == CTL_BUSY) // see R15
		begin
			rh_reg <= {4'h0, res_j[11:8]};
			rl_reg <= res_j[7:0];
		end
	end

	// Read interlock; a high-byte read arms it, a low-byte read releases it
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			lock_reg <= 1'b0;
		else if (rd_rl)
			lock_reg <= 1'b0;
		else if (rd_rh)
			lock_reg <= 1'b1; // see R8 R11
	end

	// Completion flag and request; a set wins over a low-byte read clear, but a first control write suppresses the set
	wire conversion_complete_flag_set = xfer && (ctl_reg == CTL_BUSY) && !wr_sc1;
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			conversion_complete_flag_reg     <= 1'b0;
			complete_irq <= 1'b0;
		end
		else if (conversion_complete_flag_set)
		begin
			conversion_complete_flag_reg     <= 1'b1; // see R6
			complete_irq <= complete_interrupt_enable_reg | (complete_irq & conversion_complete_flag_reg); // see R7
		end
		else if (wr_sc1 || rd_rl)
		begin
			conversion_complete_flag_reg     <= 1'b0;
			complete_irq <= 1'b0;
		end
		else if (!complete_interrupt_enable_reg)
			complete_irq <= 1'b0;
	end

	// Selector decode to the analogue multiplexer
	always_comb
	begin
		case (chsel_reg)
			5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09:
				src_next = SRC_PIN; // see R1
			5'h06, 5'h07, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F,
			5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15:
				src_next = SRC_VREFL;
			`SACC_CH_TEMP:  src_next = SRC_TEMP;
			`SACC_CH_BGAP:  src_next = SRC_BGAP;
			`SACC_CH_VREFH: src_next = SRC_VREFH;
			`SACC_CH_VREFL: src_next = SRC_VREFL;
			`SACC_CH_OFF:   src_next = SRC_OFF;
			default:        src_next = SRC_RESERVED; // see R2
		endcase
	end

	// Analogue-facing controls; async generator runs only while converting
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			input_channel_out  <= `SACC_RST_CH;
			input_source       <= SRC_OFF;
			async_clock_enable <= 1'b0;
			low_power_config   <= 1'b0;
			conversion_active  <= 1'b0;
		end
		else
		begin
			input_channel_out  <= chsel_reg;
			input_source       <= src_next;
			async_clock_enable <= async_sel & (ctl_reg == CTL_BUSY); // see R17
			low_power_config   <= lp_reg; // see R18
			conversion_active  <= eng_busy;
		end
	end

endmodule

// ---- sacc_top_asserts.sv ----
`timescale 1ns/1ps
module sacc_top_asserts
	import sacc_pkg::*;
(
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        stop_mode_req,
	input wire logic [4:0]  input_channel_out,
	input wire sacc_src_t   input_source,
	input wire logic        sample_en,
	input wire logic        async_clock_enable,
	input wire logic        low_power_config,
	input wire logic        conversion_active,
	input wire logic        complete_irq
);
	logic       any_req;
	logic       rd_req;
	logic       cfg_wr;
	logic [3:0] act_hist;
	logic [3:0] req_hist;

	// Address-phase decodes, the cause of every bus side effect
	assign any_req = hsel && hready && htrans[1];
	assign rd_req  = any_req && !hwrite;
	assign cfg_wr  = any_req && hwrite && (haddr[7:0] == 8'h08);

	// Short history, since flag and request lag the engine by a few edges
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			act_hist <= 4'h0;
			req_hist <= 4'h0;
		end
		else
		begin
			act_hist <= {act_hist[2:0], conversion_active};
			req_hist <= {req_hist[2:0], any_req};
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus slave not ready or erred");
	rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_req))
		else $error("read data moved without a read");
	// Activity flag is one register behind the engine, so look one edge later
	samp_busy_a: assert property (sample_en |=> conversion_active)
		else $error("sampling while idle");
	off_idle_a: assert property ((input_source == SRC_OFF)[*4] |-> !conversion_active)
		else $error("conversion with selector off");
	temp_dec_a: assert property ((input_channel_out == 5'h1A)[*2] |-> input_source == SRC_TEMP)
		else $error("temperature code misdecoded");
	pin_dec_a: assert property ((input_channel_out < 5'h06)[*2] |-> input_source == SRC_PIN)
		else $error("pin code misdecoded");
	resv_dec_a: assert property ((input_channel_out == 5'h1C)[*2] |-> input_source == SRC_RESERVED)
		else $error("reserved code misdecoded");
	irq_cause_a: assert property ($rose(complete_irq) |-> |act_hist)
		else $error("interrupt without a conversion");
	irq_drop_a: assert property ($fell(complete_irq) |-> |req_hist)
		else $error("interrupt dropped without a bus access");
	stop_abort_a: assert property (stop_mode_req[*6] |-> !conversion_active || async_clock_enable)
		else $error("conversion survives stop");
	lp_cause_a: assert property ($changed(low_power_config) |-> $past(cfg_wr, 2) || $past(cfg_wr, 3))
		else $error("low power bit moved without a write");
	// Generator leads the activity flag by an edge and spans the restart gap
	async_busy_a: assert property (async_clock_enable[*3] |->
		conversion_active || |act_hist[1:0])
		else $error("async clock on while idle");
endmodule

bind sacc_top sacc_top_asserts i_chk (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hrdata, .hreadyout, .hresp, .stop_mode_req, .input_channel_out, .input_source, .sample_en,
	.async_clock_enable, .low_power_config, .conversion_active, .complete_irq);

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top
	import sacc_pkg::*;
;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	wire logic   hready;
	logic        hw_trigger_pin = 1'b0;
	logic        stop_mode_req = 1'b0;
	logic        comparator_in = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [4:0]  input_channel_out;
	sacc_src_t   input_source;
	logic        sample_en;
	logic [11:0] dac_code;
	logic        async_clock_enable;
	logic        low_power_config;
	logic        conversion_active;
	logic        complete_irq;
	int          mismatches = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          seed = 38747;
	logic [7:0]  q [$];
	logic        rd_ph = 1'b0;
	logic        bitv;
	logic [4:0]  codes [8] = '{5'h00, 5'h09, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
	sacc_src_t   srcs [8] = '{SRC_PIN, SRC_PIN, SRC_TEMP, SRC_BGAP, SRC_RESERVED, SRC_VREFH,
		SRC_VREFL, SRC_OFF};

	sacc_top i_dut (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .hw_trigger_pin, .stop_mode_req, .comparator_in,
		.input_channel_out, .input_source, .sample_en, .dac_code, .async_clock_enable,
		.low_power_config, .conversion_active, .complete_irq);

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;
	always #25 mclk = ~mclk;

	task automatic tally_and_finish;
		if (mismatches == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Data phase read check, oldest note first; also the hang guard
	always @(posedge mclk)
	begin
		if (rd_ph)
			check(hrdata, {24'h0, q.pop_front()});
		rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			tally_and_finish;
		end
	end

	// Address phase held until ready, then data phase until ready
	task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		bus(a, 1'b0, 8'h00);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic wait_idle;
		while (conversion_active !== 1'b0) @(posedge mclk);
	endtask

	// Main sequence; each conversion takes 32 clocks with divider 1
	initial
	begin
		tick(5);
		sys_rst <= 1'b0;
		tick(1);
		rd(8'h00, 8'h1F);
		rd(8'h14, 8'h00);
		rd(8'h18, 8'h00);
		rd(8'h1C, 8'h00);
		wr(8'h08, 8'h24);
		for (int i = 0; i < 8; i++)
		begin
			wr(8'h00, {3'h0, codes[i]});
			tick(5);
			check(32'(input_source), 32'(srcs[i]));
			check(32'(conversion_active), 32'(codes[i] != 5'h1F));
		end
		bitv = 1'($random(seed));
		comparator_in <= bitv;
		tick(4);
		wr(8'h00, 8'h40);
		while (complete_irq !== 1'b1) @(posedge mclk);
		rd(8'h00, 8'hC0);
		rd(8'h14, bitv ? 8'h0F : 8'h00);
		rd(8'h18, bitv ? 8'hFF : 8'h00);
		tick(2);
		check(32'(complete_irq), 32'h0);
		// High byte read mid-conversion locks out the transfer
		comparator_in <= !bitv;
		tick(4);
		wr(8'h00, 8'h00);
		tick(4);
		rd(8'h14, bitv ? 8'h0F : 8'h00);
		tick(40);
		rd(8'h00, 8'h00);
		check(32'(conversion_active), 32'h1);
		rd(8'h18, bitv ? 8'hFF : 8'h00);
		wait_idle;
		tick(3);
		rd(8'h00, 8'h80);
		check(32'(complete_irq), 32'h0);
		rd(8'h14, bitv ? 8'h00 : 8'h0F);
		rd(8'h18, bitv ? 8'h00 : 8'hFF);
		comparator_in <= bitv;
		tick(4);
		wr(8'h00, 8'h60);
		while (complete_irq !== 1'b1) @(posedge mclk);
		tick(4);
		check(32'(conversion_active), 32'h1);
		wr(8'h04, 8'h00);
		tick(60);
		check(32'(conversion_active), 32'h0);
		rd(8'h14, bitv ? 8'h0F : 8'h00);
		rd(8'h18, bitv ? 8'hFF : 8'h00);
		// All-ones result is never below a zero compare value
		wr(8'h04, 8'h20);
		wr(8'h0C, 8'h00);
		wr(8'h10, 8'h00);
		rd(8'h14, bitv ? 8'h0F : 8'h00);
		comparator_in <= 1'b1;
		tick(4);
		wr(8'h00, 8'h00);
		tick(5);
		wait_idle;
		tick(40);
		check(32'(conversion_active), 32'h0);
		rd(8'h00, 8'h00);
		rd(8'h18, bitv ? 8'hFF : 8'h00);
		wr(8'h04, 8'h00);
		wr(8'h00, 8'h00);
		tick(8);
		stop_mode_req <= 1'b1;
		tick(6);
		check(32'(conversion_active), 32'h0);
		tick(40);
		rd(8'h00, 8'h00);
		stop_mode_req <= 1'b0;
		wr(8'h04, 8'h40);
		wr(8'h00, 8'h20);
		tick(10);
		check(32'(conversion_active), 32'h0);
		hw_trigger_pin <= 1'b1;
		tick(8);
		check(32'(conversion_active), 32'h1);
		hw_trigger_pin <= 1'b0;
		wr(8'h04, 8'h00);
		wr(8'h08, 8'hA7);
		tick(3);
		check(32'(low_power_config), 32'h1);
		wr(8'h00, 8'h00);
		tick(6);
		check(32'(async_clock_enable), 32'h1);
		wait_idle;
		tick(2);
		check(32'(async_clock_enable), 32'h0);
		check(32'(dac_code), 32'hFFF);
		// Ten-bit result, then eight-bit where a high-byte read does not block
		wr(8'h08, 8'h28);
		wr(8'h00, 8'h00);
		tick(4);
		wait_idle;
		tick(3);
		rd(8'h14, 8'h03);
		rd(8'h18, 8'hFF);
		wr(8'h08, 8'h20);
		rd(8'h14, 8'h03);
		wr(8'h00, 8'h00);
		tick(4);
		wait_idle;
		tick(3);
		rd(8'h00, 8'h80);
		rd(8'h14, 8'h00);
		rd(8'h18, 8'hFF);
		wr(8'h00, 8'h00);
		tick(8);
		sys_rst <= 1'b1;
		tick(2);
		check(32'(conversion_active), 32'h0);
		sys_rst <= 1'b0;
		tick(1);
		rd(8'h14, 8'h00);
		rd(8'h18, 8'h00);
		tick(2);
		tally_and_finish;
	end
endmodule
